// >>> include/irq_prio_pkg.sv
package irq_prio_pkg;

  // Register bus geometry
  localparam int          ADDR_W    = 3;
  localparam int          DATA_W    = 8;
  localparam int          NUM_REGS  = 6;
  localparam int          NUM_SRC   = NUM_REGS * DATA_W;

  // Register indices on the plain port
  localparam logic [2:0]  PRIO_BASE = 3'h0;
  localparam logic [2:0]  PRIO1_ADR = 3'h0;
  localparam logic [2:0]  PRIO2_ADR = 3'h1;
  localparam logic [2:0]  PRIO3_ADR = 3'h2;
  localparam logic [2:0]  PRIO4_ADR = 3'h3;
  localparam logic [2:0]  PRIO5_ADR = 3'h4;
  localparam logic [2:0]  PRIO6_ADR = 3'h5;
  localparam logic [2:0]  RCTL_ADR  = 3'h6;

  // Field position of global_priority_enable in reset_control_reg
  localparam int          GPE_BIT   = 7;
  localparam logic        GPE_RST   = 1'b0;

  // Implemented bits, register 6 in the top byte
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] IMPL_FULL =
    {8'h17, 8'hFF, 8'hFF, 8'hBF, 8'hBF, 8'hFF};
  // Small program memory variant drops capture 10/9 and timer 7/10/12 bits
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] IMPL_SMALL =
    {8'h17, 8'h17, 8'h3F, 8'hBF, 8'hBF, 8'hFF};
  // Software writable bits; serial port 2 rx/tx in register 3 are read-only
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] WR_MASK =
    {8'h17, 8'hFF, 8'hFF, 8'h8F, 8'hBF, 8'hFF};

  // Read-only serial port 2 priority bits within register 3
  localparam int          SER2_TX_BIT = 4;
  localparam int          SER2_RX_BIT = 5;

  // Bits cut on the small variant, as flat source indices
  localparam int          CAP9_SRC    = 30;
  localparam int          CAP10_SRC   = 31;
  localparam int          T7OVF_SRC   = 35;
  localparam int          T10_SRC     = 37;
  localparam int          T12_SRC     = 38;
  localparam int          T7GATE_SRC  = 39;

endpackage

// >>> src/priority_byte_reg.sv
`timescale 1ns/10ps
module priority_byte_reg
  import irq_prio_pkg::*;
#(
  parameter logic [DATA_W-1:0] IMPL  = 8'hFF,
  parameter logic [DATA_W-1:0] WMASK = 8'hFF
) (
  input  wire logic              core_clk,  // System clock
  input  wire logic              reset,     // Synchronous reset, active high
  input  wire logic              wr_en,     // Write strobe decoded for this byte
  input  wire logic [DATA_W-1:0] wdata,     // Write data
  output logic      [DATA_W-1:0] prio_q     // Stored priority bits
);

  logic [DATA_W-1:0] prio_ff;
  logic [DATA_W-1:0] nxt_prio;

  // Read-only bits hold their value; unimplemented bits stay zero
  always_comb begin
    nxt_prio = ((wdata & WMASK) | (prio_ff & ~WMASK)) & IMPL;
  end

  // All implemented bits start at high priority
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prio_ff <= IMPL;
    end else if (wr_en) begin
      prio_ff <= nxt_prio;
    end
  end

  assign prio_q = prio_ff;

endmodule

// >>> src/peripheral_irq_priority_bank.sv
//  Operation
// - Six priority registers hold one select bit per peripheral source.
// - Select bits act only while the global priority enable bit is set.
// - A select bit of one means high priority, zero means low.
// - Reset sets every implemented select bit to one.
// - Unimplemented bits of registers two, three and six read zero.
// - Serial port 2 rx/tx bits in register three are read-only ones.
// - Small memory variant drops capture 9/10 and timer 7/10/12 bits.
// - Register one: parallel port, converter, serial 1, sync serial 1, timers.
// - Register two: osc fail, sync serial 2, collisions, voltage, timer 3.
// - Register three: timer 5 gate, serial 2, charge time, captures, calendar.
// - Register four: capture units 10 down to 3 in bits 7 to 0.
// - Register five: timers 7, 12, 10, 8, 7, 6, 5, 4.
// - Register six: data memory write bit 4, comparators 3-1 bits 2-0.
// - With enable clear the controller runs a single priority level.
`timescale 1ns/10ps
module peripheral_irq_priority_bank
  import irq_prio_pkg::*;
#(
  parameter bit SMALL_MEM = 1'b0
) (
  input  wire logic               core_clk,        // System clock, 10 MHz
  input  wire logic               reset,           // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0]  reg_addr,        // Register index
  input  wire logic [DATA_W-1:0]  reg_wdata,       // Write data
  input  wire logic               reg_wr,          // Write strobe
  input  wire logic               reg_rd,          // Read strobe
  output logic      [DATA_W-1:0]  reg_rdata,       // Read data, cycle after strobe
  input  wire logic [NUM_SRC-1:0] irq_pending,     // Flag and enable per source
  output logic                    priority_levels_on, // Two-level mode active
  output logic      [NUM_SRC-1:0] source_high_prio,   // Effective level per source
  output logic                    high_irq_req,    // Request to the high vector
  output logic                    low_irq_req      // Request to the low vector
);

  localparam logic [NUM_REGS-1:0][DATA_W-1:0] IMPL_EFF =
    SMALL_MEM ? IMPL_SMALL : IMPL_FULL;
  localparam logic [NUM_SRC-1:0] IMPL_ALL = IMPL_EFF;

  logic [NUM_REGS-1:0][DATA_W-1:0] prio_q;
  logic [NUM_SRC-1:0]              prio_all;
  logic                            gpe_ff;
  logic [DATA_W-1:0]               rdata_ff;
  logic [DATA_W-1:0]               nxt_rdata;
  logic [NUM_SRC-1:0]              eff_high_ff;
  logic [NUM_SRC-1:0]              nxt_eff_high;
  logic                            levels_on_ff;
  logic                            high_req_ff;
  logic                            low_req_ff;
  logic [NUM_SRC-1:0]              live_pend;

  assign prio_all = prio_q;

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_bank
    priority_byte_reg #(
      .IMPL  (IMPL_EFF[i]),
      .WMASK (WR_MASK[i])
    ) u_byte (
      .core_clk (core_clk),
      .reset    (reset),
      .wr_en    (reg_wr && (reg_addr == PRIO_BASE + 3'(i))),
      .wdata    (reg_wdata),
      .prio_q   (prio_q[i])
    );
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gpe_ff <= GPE_RST;
    end else if (reg_wr && reg_addr == RCTL_ADR) begin
      gpe_ff <= reg_wdata[GPE_BIT];
    end
  end

  // Read mux; unmapped indices and unowned control bits read zero
  always_comb begin
    nxt_rdata = '0;
    case (reg_addr)
      PRIO1_ADR: begin
        nxt_rdata = prio_q[0];
      end
      PRIO2_ADR: begin
        nxt_rdata = prio_q[1];
      end
      PRIO3_ADR: begin
        nxt_rdata = prio_q[2];
      end
      PRIO4_ADR: begin
        nxt_rdata = prio_q[3];
      end
      PRIO5_ADR: begin
        nxt_rdata = prio_q[4];
      end
      PRIO6_ADR: begin
        nxt_rdata = prio_q[5];
      end
      RCTL_ADR: begin
        nxt_rdata[GPE_BIT] = gpe_ff;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  always_comb begin
    if (gpe_ff) begin
      nxt_eff_high = prio_all & IMPL_ALL;
    end else begin
      nxt_eff_high = IMPL_ALL;
    end
  end

  assign live_pend = irq_pending & IMPL_ALL;

  // Levels are registered once so every output comes from a flop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eff_high_ff  <= '0;
      levels_on_ff <= 1'b0;
    end else begin
      eff_high_ff  <= nxt_eff_high;
      levels_on_ff <= gpe_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      high_req_ff <= 1'b0;
      low_req_ff  <= 1'b0;
    end else begin
      high_req_ff <= |(live_pend & nxt_eff_high);
      low_req_ff  <= gpe_ff && |(live_pend & ~nxt_eff_high);
    end
  end

  assign reg_rdata          = rdata_ff;
  assign priority_levels_on = levels_on_ff;
  assign source_high_prio   = eff_high_ff;
  assign high_irq_req       = high_req_ff;
  assign low_irq_req        = low_req_ff;

  // Checks, all in the single clock domain
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_wr_prio1;
    reg_wr && reg_addr == PRIO1_ADR;
  endsequence

  sequence s_gpe_set;
    reg_wr && reg_addr == RCTL_ADR && reg_wdata[GPE_BIT];
  endsequence

  sequence s_gpe_clr;
    reg_wr && reg_addr == RCTL_ADR && !reg_wdata[GPE_BIT];
  endsequence

  property p_bank_write;
    s_wr_prio1 |=> prio_all[7:0] == $past(reg_wdata);
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("priority register one did not take the written byte");

  property p_gpe_on_path;
    s_gpe_set ##1 (!reg_wr) |=> gpe_ff
      ##1 (source_high_prio == $past(prio_all & IMPL_ALL, 2));
  endproperty
  a_gpe_on_path: assert property (p_gpe_on_path)
    else $error("enabled levels did not follow the stored bits");

  property p_low_route;
    gpe_ff && |(irq_pending & IMPL_ALL & ~prio_all) |=> low_irq_req;
  endproperty
  a_low_route: assert property (p_low_route)
    else $error("low priority source did not raise the low request");

  property p_high_route;
    |(irq_pending & IMPL_ALL & prio_all) |=> high_irq_req;
  endproperty
  a_high_route: assert property (p_high_route)
    else $error("high priority source did not raise the high request");

  property p_reset_value;
    $fell(reset) |-> (prio_all == IMPL_ALL) && !gpe_ff;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("reset values of the priority bits are wrong");

  property p_unimpl_zero;
    reg_rd && (reg_addr == PRIO2_ADR || reg_addr == PRIO3_ADR)
      |=> reg_rdata[6] == 1'b0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit 6 did not read zero");

  property p_reg6_zero;
    reg_rd && reg_addr == PRIO6_ADR |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[3];
  endproperty
  a_reg6_zero: assert property (p_reg6_zero)
    else $error("unimplemented bits of register six did not read zero");

  property p_ser2_ro;
    reg_wr && reg_addr == PRIO3_ADR
      |=> prio_q[2][SER2_RX_BIT] && prio_q[2][SER2_TX_BIT];
  endproperty
  a_ser2_ro: assert property (p_ser2_ro)
    else $error("read-only serial port 2 bits changed on a write");

  property p_small_variant;
    SMALL_MEM |-> !(prio_all[CAP9_SRC] || prio_all[CAP10_SRC]
      || prio_all[T7OVF_SRC] || prio_all[T10_SRC]
      || prio_all[T12_SRC] || prio_all[T7GATE_SRC]);
  endproperty
  a_small_variant: assert property (p_small_variant)
    else $error("bit cut on the small variant is set");

  property p_read_reg1;
    reg_rd && reg_addr == PRIO1_ADR |=> reg_rdata == $past(prio_all[7:0]);
  endproperty
  a_read_reg1: assert property (p_read_reg1)
    else $error("register one read back the wrong value");

  property p_read_reg2;
    reg_rd && reg_addr == PRIO2_ADR |=> reg_rdata == $past(prio_q[1]);
  endproperty
  a_read_reg2: assert property (p_read_reg2)
    else $error("register two read back the wrong value");

  property p_read_reg3;
    reg_rd && reg_addr == PRIO3_ADR |=> reg_rdata == $past(prio_q[2]);
  endproperty
  a_read_reg3: assert property (p_read_reg3)
    else $error("register three read back the wrong value");

  property p_read_reg4;
    reg_rd && reg_addr == PRIO4_ADR |=> reg_rdata == $past(prio_all[31:24]);
  endproperty
  a_read_reg4: assert property (p_read_reg4)
    else $error("register four read back the wrong value");

  property p_read_reg5;
    reg_rd && reg_addr == PRIO5_ADR |=> reg_rdata == $past(prio_all[39:32]);
  endproperty
  a_read_reg5: assert property (p_read_reg5)
    else $error("register five read back the wrong value");

  property p_read_reg6;
    reg_rd && reg_addr == PRIO6_ADR |=> reg_rdata == $past(prio_all[47:40]);
  endproperty
  a_read_reg6: assert property (p_read_reg6)
    else $error("register six read back the wrong value");

  property p_single_level;
    s_gpe_clr |=> !gpe_ff ##1 (!priority_levels_on && source_high_prio == IMPL_ALL);
  endproperty
  a_single_level: assert property (p_single_level)
    else $error("single level mode did not force all sources high");

  property p_no_low_when_off;
    !gpe_ff |=> !low_irq_req;
  endproperty
  a_no_low_when_off: assert property (p_no_low_when_off)
    else $error("low request raised with levels disabled");

  property p_compat_high;
    !gpe_ff && |(irq_pending & IMPL_ALL) |=> high_irq_req;
  endproperty
  a_compat_high: assert property (p_compat_high)
    else $error("single level mode did not send a pending source high");

  property p_store_when_off;
    !gpe_ff && reg_wr && reg_addr == PRIO4_ADR
      |=> prio_all[31:24] == ($past(reg_wdata) & IMPL_EFF[3]);
  endproperty
  a_store_when_off: assert property (p_store_when_off)
    else $error("priority write was lost with levels disabled");

  property p_rdata_one_cycle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle)
    else $error("read data stood outside its answer cycle");

endmodule

// >>> testbench/peripheral_irq_priority_bank_bench.sv
`timescale 1ns/10ps
module peripheral_irq_priority_bank_bench;
  import irq_prio_pkg::*;

  logic               core_clk;
  logic               reset;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [DATA_W-1:0]  reg_rdata;
  logic [NUM_SRC-1:0] irq_pending;
  logic               priority_levels_on;
  logic [NUM_SRC-1:0] source_high_prio;
  logic               high_irq_req;
  logic               low_irq_req;
  logic [NUM_SRC-1:0] small_high_prio;
  logic [DATA_W-1:0]  got;
  int                 n_mismatch;
  int                 checks_done;
  int                 cycle_cnt;

  // Expected images, register 1 first
  localparam logic [DATA_W-1:0] RST_VAL [NUM_REGS] =
    '{8'hFF, 8'hBF, 8'hBF, 8'hFF, 8'hFF, 8'h17};
  localparam logic [DATA_W-1:0] WR_BITS [NUM_REGS] =
    '{8'hFF, 8'hBF, 8'h8F, 8'hFF, 8'hFF, 8'h17};
  localparam logic [NUM_SRC-1:0] FULL_IMPL  = 48'h17FFFFBFBFFF;
  localparam logic [NUM_SRC-1:0] SMALL_IMPL = 48'h17173FBFBFFF;

  peripheral_irq_priority_bank #(.SMALL_MEM(1'b0)) u_peripheral_irq_priority_bank (
    .core_clk           (core_clk),
    .reset              (reset),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .irq_pending        (irq_pending),
    .priority_levels_on (priority_levels_on),
    .source_high_prio   (source_high_prio),
    .high_irq_req       (high_irq_req),
    .low_irq_req        (low_irq_req)
  );

  // Second variant shares the bus so every write lands in both
  peripheral_irq_priority_bank #(.SMALL_MEM(1'b1)) u_peripheral_irq_priority_bank_small (
    .core_clk           (core_clk),
    .reset              (reset),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (),
    .irq_pending        (irq_pending),
    .priority_levels_on (),
    .source_high_prio   (small_high_prio),
    .high_irq_req       (),
    .low_irq_req        ()
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the full sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 3000) begin
      n_mismatch++;
      final_report;
    end
  end

  task automatic chk_byte(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic chk_vec(input logic [NUM_SRC-1:0] g, input logic [NUM_SRC-1:0] e,
                         input string m);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, m, g, e);
    end
  endtask

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask

  task automatic pend_chk(input int k, input logic exp_hi, input logic exp_lo);
    logic [NUM_SRC-1:0] v;
    v    = '0;
    v[k] = 1'b1;
    @(posedge core_clk);
    irq_pending <= v;
    @(posedge core_clk);
    #1;
    chk_bit(high_irq_req, exp_hi, "high request");
    chk_bit(low_irq_req, exp_lo, "low request");
    @(posedge core_clk);
    irq_pending <= '0;
  endtask

  task automatic t_reset_state;
    for (int r = 0; r < 8; r++) begin
      bus_rd(r[ADDR_W-1:0], got);
      chk_byte(got, (r < NUM_REGS) ? RST_VAL[r] : 8'h00, "reset value");
    end
    chk_vec(source_high_prio, FULL_IMPL, "reset levels");
    chk_vec(small_high_prio, SMALL_IMPL, "small variant levels");
    chk_bit(priority_levels_on, 1'b0, "levels off after reset");
    pend_chk(0, 1'b1, 1'b0);
  endtask

  task automatic t_write_masks;
    for (int r = 0; r < 8; r++) begin
      bus_wr(r[ADDR_W-1:0], 8'h00);
    end
    for (int r = 0; r < 8; r++) begin
      bus_rd(r[ADDR_W-1:0], got);
      chk_byte(got, (r < NUM_REGS) ? (RST_VAL[r] & ~WR_BITS[r]) : 8'h00, "clear");
    end
    chk_vec(source_high_prio, FULL_IMPL, "levels ignored");
    pend_chk(0, 1'b1, 1'b0);
    for (int r = 0; r < NUM_REGS; r++) begin
      bus_wr(r[ADDR_W-1:0], 8'hFF);
      bus_rd(r[ADDR_W-1:0], got);
      chk_byte(got, RST_VAL[r], "set all");
    end
  endtask

  task automatic t_enable_levels;
    bus_wr(RCTL_ADR, 8'hFF);
    bus_rd(RCTL_ADR, got);
    chk_byte(got, 8'h80, "enable readback");
    chk_bit(priority_levels_on, 1'b1, "levels on");
    bus_wr(PRIO1_ADR, 8'h00);
    settle;
    chk_vec(source_high_prio, FULL_IMPL & ~48'h0000000000FF, "low sources");
    pend_chk(0, 1'b0, 1'b1);
    pend_chk(8, 1'b1, 1'b0);
    pend_chk(14, 1'b0, 1'b0);
    bus_wr(RCTL_ADR, 8'h00);
    settle;
    chk_bit(priority_levels_on, 1'b0, "levels off");
    pend_chk(0, 1'b1, 1'b0);
    bus_rd(PRIO1_ADR, got);
    chk_byte(got, 8'h00, "stored while off");
  endtask

  task automatic t_bit_map(input logic [DATA_W-1:0] pat);
    logic [NUM_SRC-1:0] exp;
    exp = FULL_IMPL;
    bus_wr(RCTL_ADR, 8'h80);
    for (int r = 0; r < NUM_REGS; r++) begin
      bus_wr(r[ADDR_W-1:0], pat);
      exp[r*DATA_W +: DATA_W] = (pat & WR_BITS[r]) | (RST_VAL[r] & ~WR_BITS[r]);
    end
    settle;
    chk_vec(source_high_prio, exp, "bit map");
    chk_vec(small_high_prio, exp & SMALL_IMPL, "small bit map");
    pend_chk(44, exp[44], ~exp[44]);
    pend_chk(31, exp[31], ~exp[31]);
    bus_wr(RCTL_ADR, 8'h00);
  endtask

  // Reset in mid-run must undo earlier writes and the enable
  task automatic t_mid_reset;
    bus_wr(PRIO4_ADR, 8'h00);
    bus_wr(RCTL_ADR, 8'h80);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    for (int r = 0; r < 7; r++) begin
      bus_rd(r[ADDR_W-1:0], got);
      chk_byte(got, (r < NUM_REGS) ? RST_VAL[r] : 8'h00, "value after reset");
    end
    chk_bit(priority_levels_on, 1'b0, "levels off after mid reset");
    chk_vec(source_high_prio, FULL_IMPL, "levels after mid reset");
    chk_vec(small_high_prio, SMALL_IMPL, "small levels after mid reset");
  endtask

  initial begin
    reset       = 1'b1;
    reg_addr    = '0;
    reg_wdata   = '0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    irq_pending = '0;
    n_mismatch  = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_state;
    t_write_masks;
    t_enable_levels;
    t_mid_reset;
    t_bit_map(8'h5A);
    t_bit_map(8'hA5);
    final_report;
  end

endmodule
